// File: bench/wext_timer_model.sv
/*
 Stand-in for the two timers: compare levels and update strobes.
 Assumes callers run in the clk_sys domain.
*/
`timescale 1ns/1ps
module wext_timer_model (
  // Clock
  input wire clk_sys,
  // Timer side
  output reg [3:0] timer_a_cmp,
  output reg [1:0] timer_b_cmp,
  output reg timer_a_update,
  output reg timer_b_update
);
  initial {timer_a_cmp, timer_b_cmp, timer_a_update, timer_b_update} = 8'h00;
  task set_cmp(input [3:0] a, input [1:0] b);
    @(posedge clk_sys);
    timer_a_cmp <= a;
    timer_b_cmp <= b;
  endtask
  // One-cycle strobe, from either timer
  task update(input bit use_b);
    @(posedge clk_sys);
    timer_a_update <= !use_b;
    timer_b_update <= use_b;
    @(posedge clk_sys);
    {timer_a_update, timer_b_update} <= 2'h0;
  endtask
endmodule // wext_timer_model

// File: bench/wext_top_sva.sv
/*
 Port assertions for the waveform extension top.
 Assumes a bind to every wext_top instance.
*/
`timescale 1ns/1ps
`include "wext_consts.vh"
module wext_top_sva #(
  parameter NPIN = 8,
  parameter NDT = 4,
  parameter DT_W = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Inputs
  input wire [3:0] timer_a_cmp,
  input wire [1:0] timer_b_cmp,
  input wire timer_a_update,
  input wire timer_b_update,
  input wire [`WEXT_RT_W-1:0] route_sel,
  input wire [NDT-1:0] dt_enable,
  input wire [NDT*DT_W-1:0] dead_low_len,
  input wire [NDT*DT_W-1:0] dead_high_len,
  input wire swap_wr,
  input wire pat_wr,
  // Outputs
  input wire [NPIN-1:0] pin_out_ff,
  input wire [NDT-1:0] swap_act_ff,
  input wire [NPIN-1:0] pat_en_act_ff,
  input wire swap_pending_ff,
  input wire pat_pending_ff
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wire upd = timer_a_update | timer_b_update;
  wire quiet = ~|swap_act_ff && ~|pat_en_act_ff;
  // Three quiet cycles cover the two-register path from timer_a_cmp to the pins
  wire dt0 = route_sel == 3'h0 && dt_enable == 4'h1 && quiet &&
    ~|dead_low_len[7:0] && ~|dead_high_len[7:0];
  a_route_default: assert property (route_sel == 3'h0 && ~|dt_enable &&
    quiet |=> pin_out_ff == $past({timer_b_cmp, timer_b_cmp, timer_a_cmp}))
    else $error("default routing wrong");
  a_no_overlap: assert property (dt_enable[0] && ~|pat_en_act_ff[1:0]
    |=> pin_out_ff[1:0] != 2'h3) else $error("pair overlap");
  a_zero_gap: assert property (dt0 [*3] |=> pin_out_ff[1:0] ==
    {~$past(timer_a_cmp[0], 2), $past(timer_a_cmp[0], 2)})
    else $error("no exact complement");
  a_swap_staged: assert property (swap_wr |=> swap_pending_ff)
    else $error("swap not staged");
  a_swap_held: assert property (!swap_pending_ff |=> $stable(swap_act_ff))
    else $error("swap applied early");
  a_swap_moved: assert property (upd && swap_pending_ff && !swap_wr
    |=> !swap_pending_ff) else $error("swap not moved");
  a_pat_staged: assert property (pat_wr |=> pat_pending_ff)
    else $error("pattern not staged");
  a_pat_held: assert property (!pat_pending_ff |=> $stable(pat_en_act_ff))
    else $error("pattern applied early");
  a_pat_moved: assert property (upd && pat_pending_ff && !pat_wr
    |=> !pat_pending_ff) else $error("pattern not moved");
  c_swap: cover property (upd && swap_pending_ff);
  c_pat: cover property (upd && pat_pending_ff);
  c_zero: cover property (dt0 [*3]);
endmodule // wext_top_sva
bind wext_top wext_top_sva #(.NPIN(NPIN), .NDT(NDT), .DT_W(DT_W)) u_sva (
  .clk_sys, .arst_n, .timer_a_cmp, .timer_b_cmp, .timer_a_update,
  .timer_b_update, .route_sel, .dt_enable, .dead_low_len, .dead_high_len,
  .swap_wr, .pat_wr, .pin_out_ff, .swap_act_ff, .pat_en_act_ff,
  .swap_pending_ff, .pat_pending_ff);

// File: bench/wext_top_tb.sv
/*
 Self-checking bench for the waveform extension top.
 Assumes the timer model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
  errors++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module wext_top_tb;
  reg clk_sys = 1'b0;
  reg arst_n = 1'b0;
  reg [2:0] route_sel = 3'h0;
  reg [3:0] dt_enable = 4'h0, swap_wdata = 4'h0;
  reg [31:0] dead_low_len = 32'h0, dead_high_len = 32'h0;
  reg [7:0] pat_en_wdata = 8'h00, pat_val_wdata = 8'h00;
  reg swap_wr = 1'b0, pat_wr = 1'b0;
  wire [3:0] timer_a_cmp, swap_act_ff;
  wire [1:0] timer_b_cmp;
  wire timer_a_update, timer_b_update, swap_pending_ff, pat_pending_ff;
  wire [7:0] pin_out_ff, pat_en_act_ff;
  int errors = 0, n_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  wext_timer_model u_wext_timer_model (.clk_sys, .timer_a_cmp,
    .timer_b_cmp, .timer_a_update, .timer_b_update);
  wext_top u_wext_top (.clk_sys, .arst_n, .timer_a_cmp, .timer_b_cmp,
    .timer_a_update, .timer_b_update, .route_sel, .dt_enable,
    .dead_low_len, .dead_high_len, .swap_wdata, .swap_wr, .pat_en_wdata,
    .pat_val_wdata, .pat_wr, .pin_out_ff, .swap_act_ff, .pat_en_act_ff,
    .swap_pending_ff, .pat_pending_ff);
  // ----
  // Scenarios
  // ----
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task t_route;
    reg [3:0] a;
    reg [1:0] b;
    reg [7:0] e[6];
    a = 4'hd;
    b = 2'h1;
    e = '{{b, b, a}, {b, b, a[1:0], a[1:0]}, {b, a[3:2], b, a[1:0]},
      {{4{a[1]}}, {4{a[0]}}}, {a, b[1], b[1], b[0], b[0]}, {b, b, a}};
    u_wext_timer_model.set_cmp(a, b);
    for (int r = 0; r < 6; r++)
    begin
      @(posedge clk_sys);
      route_sel <= r[2:0];
      cyc(2);
      `CHK("route", e[r], pin_out_ff)
    end
    $display("route test done");
  endtask
  task t_dead(input [2:0] r, input [7:0] lo_len, hi_len, input bit on_b);
    int off;
    @(posedge clk_sys);
    route_sel <= r;
    dt_enable <= 4'h1;
    dead_low_len <= {24'h0, lo_len};
    dead_high_len <= {24'h0, hi_len};
    u_wext_timer_model.set_cmp(4'h0, 2'h0);
    cyc(20);
    for (int v = 1; v >= 0; v--)
    begin
      u_wext_timer_model.set_cmp(4'(v & !on_b), 2'(v & on_b));
      off = 0;
      repeat (20)
      begin
        @(posedge clk_sys);
        // Sample clear of the edge's own updates
        #1 off += (pin_out_ff[1:0] == 2'h0);
      end
      `CHK("gap", v ? lo_len : hi_len, 8'(off))
      `CHK("pair", v ? 2'h1 : 2'h2, pin_out_ff[1:0])
    end
    $display("dead time test done");
  endtask
  task t_swap;
    @(posedge clk_sys);
    swap_wdata <= 4'h1;
    swap_wr <= 1'b1;
    @(posedge clk_sys);
    swap_wr <= 1'b0;
    cyc(3);
    `CHK("swap held", 6'h02, {swap_act_ff, pin_out_ff[1:0]})
    u_wext_timer_model.update(1'b1);
    cyc(2);
    `CHK("swap act", 5'h02, {swap_act_ff, swap_pending_ff})
    `CHK("swap pins", 2'h1, pin_out_ff[1:0])
    // Swap with the unit off exchanges the raw matrix pins
    @(posedge clk_sys);
    route_sel <= 3'h0;
    dt_enable <= 4'h0;
    u_wext_timer_model.set_cmp(4'h1, 2'h0);
    cyc(2);
    `CHK("swap raw", 2'h2, pin_out_ff[1:0])
    u_wext_timer_model.set_cmp(4'h0, 2'h0);
    @(posedge clk_sys);
    dt_enable <= 4'h1;
    $display("swap test done");
  endtask
  task t_pat;
    @(posedge clk_sys);
    pat_en_wdata <= 8'hff;
    pat_val_wdata <= 8'ha5;
    pat_wr <= 1'b1;
    @(posedge clk_sys);
    pat_wr <= 1'b0;
    cyc(3);
    `CHK("pat held", 8'h01, pin_out_ff)
    u_wext_timer_model.update(1'b0);
    cyc(2);
    `CHK("pat act", 9'h1fe, {pat_en_act_ff, pat_pending_ff})
    `CHK("pat pins", 8'ha5, pin_out_ff)
    $display("pattern test done");
  endtask
  // ----
  // Verdict
  // ----
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    arst_n <= 1'b1;
    t_route;
    t_dead(3'h0, 8'h03, 8'h05, 1'b0);
    t_dead(3'h4, 8'h00, 8'h00, 1'b1);
    t_dead(3'h0, 8'h00, 8'h00, 1'b0);
    t_swap;
    t_pat;
    give_verdict;
  end
  // Tests need well under a thousand cycles
  initial
  begin
    cyc(5000);
    errors++;
    give_verdict;
  end
endmodule // wext_top_tb

// File: hdl/wext_consts.vh
/*
 Constants for the waveform extension: routing configurations,
 dead-time widths, reset values and pin-group sizes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef WEXT_CONSTS_VH
`define WEXT_CONSTS_VH
// ----------------------------------------------------------------
// Routing configurations
// ----------------------------------------------------------------
`define WEXT_RT_W 3
`define WEXT_RT_DEFAULT 3'h0
`define WEXT_RT_DT_A 3'h1
`define WEXT_RT_SPLIT 3'h2
`define WEXT_RT_FANOUT 3'h3
`define WEXT_RT_DT_B 3'h4
// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define WEXT_NPIN 8
`define WEXT_NDT 4
`define WEXT_DT_W 8
`define WEXT_DT_ZERO 8'h00
`define WEXT_PIN_ZERO 8'h00
`define WEXT_DT_ONE 8'h01
`endif

// File: hdl/wext_dead_time.v
/*
 One dead-time unit: turns one waveform into a complementary
 low-side and high-side pair with separate dead lengths.
 Assumes a single clock and inputs synchronous to it.
*/
`timescale 1ns/1ps
`include "wext_consts.vh"
module wext_dead_time #(
  parameter DT_W = `WEXT_DT_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Waveform and settings
  input wire wave_in,
  input wire [DT_W-1:0] dead_low,
  input wire [DT_W-1:0] dead_high,
  // Drives
  output reg low_side_out,
  output reg high_side_out
);
  reg wave_d_ff;
  reg [DT_W-1:0] cnt_ff;
  reg [DT_W-1:0] nxt_cnt;
  reg nxt_low;
  reg nxt_high;
  wire rise;
  wire fall;
  assign rise = wave_in & ~wave_d_ff;
  assign fall = ~wave_in & wave_d_ff;
  // ----------------------------------------------------------------
  // Edge handling
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_cnt = cnt_ff;
    nxt_low = low_side_out;
    nxt_high = high_side_out;
    if (rise)
    begin
      // Low side waits dead_low after high side turns off
      nxt_high = 1'b0;
      if (dead_low == `WEXT_DT_ZERO)
      begin
        nxt_low = 1'b1;
        nxt_cnt = `WEXT_DT_ZERO;
      end
      else
      begin
        nxt_low = 1'b0;
        nxt_cnt = dead_low;
      end
    end
    else if (fall)
    begin
      nxt_low = 1'b0;
      if (dead_high == `WEXT_DT_ZERO)
      begin
        nxt_high = 1'b1;
        nxt_cnt = `WEXT_DT_ZERO;
      end
      else
      begin
        nxt_high = 1'b0;
        nxt_cnt = dead_high;
      end
    end
    else if (cnt_ff != `WEXT_DT_ZERO)
    begin
      nxt_cnt = cnt_ff - `WEXT_DT_ONE;
      if (cnt_ff == `WEXT_DT_ONE)
      begin
        // Gap over: turn on the side the waveform asks for
        nxt_low = wave_d_ff;
        nxt_high = ~wave_d_ff;
      end
    end
  end
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wave_d_ff <= 1'b0;
      cnt_ff <= `WEXT_DT_ZERO;
      low_side_out <= 1'b0;
      high_side_out <= 1'b1;
    end
    else
    begin
      wave_d_ff <= wave_in;
      cnt_ff <= nxt_cnt;
      low_side_out <= nxt_low;
      high_side_out <= nxt_high;
    end
  end
endmodule // wext_dead_time

// File: hdl/wext_top.v
/*
 Waveform extension top: routing matrix, four dead-time units,
 double-buffered swap and pattern stages, registered pin drives.
 Assumes timer compare outputs and update strobes are synchronous
 to clk_sys; settings are held on plain input ports.
*/
`timescale 1ns/1ps
`include "wext_consts.vh"
// Behaviour
// - Timer compare outputs reach the pins through a selectable matrix.
// - The four lowest matrix outputs feed dead-time units for paired drives.
// - Low side follows the waveform, high side its inverse, optional gap.
// - Each unit has separate 8-bit dead lengths for its low and high side.
// - Dead-time units can be shared out between timer a and timer b.
// - Four swap units exchange the low and high pin of a pair when enabled.
// - A written swap setting is staged and not applied at once.
// - A pattern stage can force constant levels on the pins over waves.
// - Pattern values are staged and reach all pins together on transfer.
module wext_top #(
  parameter NPIN = `WEXT_NPIN,
  parameter NDT = `WEXT_NDT,
  parameter DT_W = `WEXT_DT_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Timer compare outputs and update events
  input wire [3:0] timer_a_cmp,
  input wire [1:0] timer_b_cmp,
  input wire timer_a_update,
  input wire timer_b_update,
  // Routing and dead time
  input wire [`WEXT_RT_W-1:0] route_sel,
  input wire [NDT-1:0] dt_enable,
  input wire [NDT*DT_W-1:0] dead_low_len,
  input wire [NDT*DT_W-1:0] dead_high_len,
  // Swap staging
  input wire [NDT-1:0] swap_wdata,
  input wire swap_wr,
  // Pattern staging
  input wire [NPIN-1:0] pat_en_wdata,
  input wire [NPIN-1:0] pat_val_wdata,
  input wire pat_wr,
  // Pins and status
  output reg [NPIN-1:0] pin_out_ff,
  output reg [NDT-1:0] swap_act_ff,
  output reg [NPIN-1:0] pat_en_act_ff,
  output reg swap_pending_ff,
  output reg pat_pending_ff
);
  reg [NDT-1:0] swap_buf_ff;
  reg [NPIN-1:0] pat_en_buf_ff;
  reg [NPIN-1:0] pat_val_buf_ff;
  reg [NPIN-1:0] pat_val_act_ff;
  reg [NPIN-1:0] mtx;
  reg [NPIN-1:0] nxt_pin;
  reg nxt_swap_pending;
  reg nxt_pat_pending;
  wire [NDT-1:0] dt_low;
  wire [NDT-1:0] dt_high;
  wire [NPIN-1:0] swp_pin;
  wire [NPIN-1:0] pat_pin;
  wire update;
  // Update from either timer; the two strobes are ORed, no owner is selected
  assign update = timer_a_update | timer_b_update;
  // ----------------------------------------------------------------
  // Output routing matrix
  // ----------------------------------------------------------------
  function [NPIN-1:0] route_map;
    input [`WEXT_RT_W-1:0] sel;
    input [3:0] a;
    input [1:0] b;
    begin
      case (sel)
        `WEXT_RT_DT_A: route_map = {b, b, a[1:0], a[1:0]};
        `WEXT_RT_SPLIT: route_map = {b, a[3:2], b, a[1:0]};
        `WEXT_RT_FANOUT: route_map = {{4{a[1]}}, {4{a[0]}}};
        `WEXT_RT_DT_B: route_map = {a, b[1], b[1], b[0], b[0]};
        default: route_map = {b, b, a};
      endcase
    end
  endfunction
  always @*
  begin
    mtx = route_map(route_sel, timer_a_cmp, timer_b_cmp);
  end
  // ----------------------------------------------------------------
  // Dead-time units on the four lowest matrix outputs
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NDT; g = g + 1)
    begin : g_dt
      wext_dead_time #(
        .DT_W(DT_W)
      ) u_dt (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wave_in(mtx[g]),
        .dead_low(dead_low_len[g*DT_W +: DT_W]),
        .dead_high(dead_high_len[g*DT_W +: DT_W]),
        .low_side_out(dt_low[g]),
        .high_side_out(dt_high[g])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // Swap and pattern selection
  // ----------------------------------------------------------------
  // Pair k uses pins 2k (low side) and 2k+1 (high side)
  // Bit 1 of the result is the high pin of the pair, bit 0 the low pin
  function [1:0] pair_pick;
    input unit_on;
    input swap_on;
    input low_drv;
    input high_drv;
    input [1:0] raw;
    begin
      if (unit_on)
        pair_pick = swap_on ? {low_drv, high_drv} : {high_drv, low_drv};
      else
        pair_pick = swap_on ? {raw[0], raw[1]} : raw;
    end
  endfunction
  generate
    for (g = 0; g < NDT; g = g + 1)
    begin : g_swap
      assign swp_pin[2*g+1:2*g] = pair_pick(dt_enable[g], swap_act_ff[g],
        dt_low[g], dt_high[g], mtx[2*g+1:2*g]);
    end
    // Pins above the last pair pass the matrix straight through
    for (g = 2*NDT; g < NPIN; g = g + 1)
    begin : g_raw
      assign swp_pin[g] = mtx[g];
    end
    // Pattern overrides after swap, one pin at a time
    for (g = 0; g < NPIN; g = g + 1)
    begin : g_pat
      assign pat_pin[g] = pat_en_act_ff[g] ? pat_val_act_ff[g] :
        swp_pin[g];
    end
  endgenerate
  always @*
  begin
    nxt_pin = pat_pin;
  end
  // ----------------------------------------------------------------
  // Double buffers
  // ----------------------------------------------------------------
  // A write wins over the clear, so a write in the update cycle
  // stays pending for the next update
  always @*
  begin
    nxt_swap_pending = swap_pending_ff;
    if (swap_wr)
      nxt_swap_pending = 1'b1;
    else if (update)
      nxt_swap_pending = 1'b0;
  end
  always @*
  begin
    nxt_pat_pending = pat_pending_ff;
    if (pat_wr)
      nxt_pat_pending = 1'b1;
    else if (update)
      nxt_pat_pending = 1'b0;
  end
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      swap_buf_ff <= {NDT{1'b0}};
      swap_act_ff <= {NDT{1'b0}};
      swap_pending_ff <= 1'b0;
    end
    else
    begin
      swap_pending_ff <= nxt_swap_pending;
      if (update && swap_pending_ff)
      begin
        swap_act_ff <= swap_buf_ff;
      end
      if (swap_wr)
      begin
        swap_buf_ff <= swap_wdata;
      end
    end
  end
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pat_en_buf_ff <= `WEXT_PIN_ZERO;
      pat_val_buf_ff <= `WEXT_PIN_ZERO;
      pat_en_act_ff <= `WEXT_PIN_ZERO;
      pat_val_act_ff <= `WEXT_PIN_ZERO;
      pat_pending_ff <= 1'b0;
    end
    else
    begin
      pat_pending_ff <= nxt_pat_pending;
      if (update && pat_pending_ff)
      begin
        pat_en_act_ff <= pat_en_buf_ff;
        pat_val_act_ff <= pat_val_buf_ff;
      end
      if (pat_wr)
      begin
        pat_en_buf_ff <= pat_en_wdata;
        pat_val_buf_ff <= pat_val_wdata;
      end
    end
  end
  // ----------------------------------------------------------------
  // Pin register
  // ----------------------------------------------------------------
  // Pins change only on the clock or on the asynchronous reset, so no decode glitch reaches a pin
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_out_ff <= `WEXT_PIN_ZERO;
    end
    else
    begin
      pin_out_ff <= nxt_pin;
    end
  end
endmodule // wext_top
